// file: rtl/cmpz_pkg.sv
// package: register map, field layout and reset values of the comparator zero config bank
`default_nettype none
package cmpz_pkg;

   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] MUX_OFFSET  = 8'h9f;
   localparam logic [7:0] MODE_OFFSET = 8'h9d;
   localparam logic [7:0] STAT_OFFSET = 8'ha0;

   // ----------------------------------------
   // field layout and reset values
   // ----------------------------------------
   localparam int         POS_SEL_LSB    = 0;
   localparam int         RISE_EN_BIT    = 5;
   localparam int         FALL_EN_BIT    = 4;
   localparam int         MODE_LSB       = 0;
   localparam logic [7:0] MODE_WR_MASK   = 8'h33;
   localparam logic [7:0] MUX_WR_MASK    = 8'h07;
   localparam logic [7:0] MODE_RESET     = 8'h02;
   localparam logic [7:0] MUX_RESET      = 8'h00;

   // response speed / power trade
   typedef enum logic [1:0] {
      CMPZ_FASTEST = 2'h0,
      CMPZ_MID_FAST = 2'h1,
      CMPZ_MID_LOW = 2'h2,
      CMPZ_LOWEST_POWER = 2'h3
   } cmpz_resp_t;

   // configuration seen by the analog macro
   typedef struct packed {
      logic [2:0] pos_sel;
      cmpz_resp_t resp_mode;
      logic       rise_en;
      logic       fall_en;
   } cmpz_cfg_t;

endpackage
`default_nettype wire

// file: rtl/cmpz_regs.sv
// module: comparator zero mux and mode registers on a classic wishbone slave
// What this block does
// - mux register low three bits select positive input pin, zero is first pin.
// - mode register bits seven and six read zero, writes to them ignored.
// - mode bit five enables rising-edge interrupt request from comparator output.
// - mode bits one and zero choose response mode, zero fastest, three lowest power.
// - mode register resets to 0x02: interrupts off, response mode two.
`timescale 1ns/1ns
`default_nettype none
module cmpz_regs (
   // clock, reset, enable
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [7:0]        adr_i,
   input  wire logic [0:0]        sel_i,
   input  wire logic [7:0]        dat_i,
   output logic      [7:0]        dat_o,
   output logic                   ack_o,
   // comparator side
   input  wire logic              cmp_out_i,
   output cmpz_pkg::cmpz_cfg_t    cfg_o,
   output logic                   rise_irq_o,
   output logic                   fall_irq_o
);

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic [7:0] cmp_a_mode_reg_q;
   logic [7:0] cmp_a_input_mux_reg_q;
   logic       cmp_prev_q;
   logic       ack_q;
   logic [7:0] dat_q;
   logic       rise_q;
   logic       fall_q;
   cmpz_pkg::cmpz_cfg_t cfg_q;

   // ----------------------------------------
   // shared decode helpers
   // ----------------------------------------
   function automatic logic adr_hit(
      input logic [7:0] adr,
      input logic [7:0] offs
   );
      return adr == offs;
   endfunction

   // only writable bits survive, the rest read back zero
   function automatic logic [7:0] keep_bits(
      input logic [7:0] data,
      input logic [7:0] mask
   );
      return data & mask;
   endfunction

   // ack drops one cycle after it rose, so no double access
   wire        req      = cyc_i & stb_i & ~ack_q;
   wire        wr       = req & we_i & sel_i[0];
   wire        hit_mode = adr_hit(adr_i, cmpz_pkg::MODE_OFFSET);
   wire        hit_mux  = adr_hit(adr_i, cmpz_pkg::MUX_OFFSET);
   wire        hit_stat = adr_hit(adr_i, cmpz_pkg::STAT_OFFSET);
   wire [7:0]  mode_d   = keep_bits(dat_i, cmpz_pkg::MODE_WR_MASK);
   wire [7:0]  mux_d    = keep_bits(dat_i, cmpz_pkg::MUX_WR_MASK);
   // unmapped addresses read zero and still ack
   wire [7:0]  rd_d     = hit_mode ? cmp_a_mode_reg_q :
                          hit_mux  ? cmp_a_input_mux_reg_q :
                          hit_stat ? {7'h00, cmp_out_i} : 8'h00;

   // ----------------------------------------
   // edge detect, gated by enables
   // ----------------------------------------
   wire        rise_edge = cmp_out_i & ~cmp_prev_q;
   wire        fall_edge = ~cmp_out_i & cmp_prev_q;
   wire        rise_d    = rise_edge & cmp_a_mode_reg_q[cmpz_pkg::RISE_EN_BIT];
   wire        fall_d    = fall_edge & cmp_a_mode_reg_q[cmpz_pkg::FALL_EN_BIT];

   wire cmpz_pkg::cmpz_cfg_t cfg_d = '{
      pos_sel:   cmp_a_input_mux_reg_q[cmpz_pkg::POS_SEL_LSB +: 3],
      resp_mode: cmpz_pkg::cmpz_resp_t'(cmp_a_mode_reg_q[cmpz_pkg::MODE_LSB +: 2]),
      rise_en:   cmp_a_mode_reg_q[cmpz_pkg::RISE_EN_BIT],
      fall_en:   cmp_a_mode_reg_q[cmpz_pkg::FALL_EN_BIT]
   };

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // mode register, unused bits masked on write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_a_mode_reg_q <= cmpz_pkg::MODE_RESET;
      end else if (ce_i && wr && hit_mode) begin
         cmp_a_mode_reg_q <= mode_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_a_input_mux_reg_q <= cmpz_pkg::MUX_RESET;
      end else if (ce_i && wr && hit_mux) begin
         cmp_a_input_mux_reg_q <= mux_d;
      end
   end

   // bus answer: one-cycle ack, read data only beside it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 8'h00;
      end else if (ce_i) begin
         ack_q <= req;
         dat_q <= req ? rd_d : 8'h00;
      end
   end

   // previous comparator level for the edge detect
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_prev_q <= 1'b0;
      end else if (ce_i) begin
         cmp_prev_q <= cmp_out_i;
      end
   end

   // plain pulses, no sticky flag kept here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else if (ce_i) begin
         rise_q <= rise_d;
         fall_q <= fall_d;
      end
   end

   // config copy lags the registers by one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q <= '0;
      end else if (ce_i) begin
         cfg_q <= cfg_d;
      end
   end

   assign ack_o      = ack_q;
   assign dat_o      = dat_q;
   assign rise_irq_o = rise_q;
   assign fall_irq_o = fall_q;
   assign cfg_o      = cfg_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // bus side
   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && ack_o) |=> !ack_o)
      else $error("ack held two cycles");

   a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && req) |=> ack_o)
      else $error("request not answered");

   a_read_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !ack_o |-> dat_o == 8'h00)
      else $error("read data outside ack");

   a_freeze_regs: assert property (@(posedge clk_i) disable iff (rst_i)
      !ce_i |=> $stable(cmp_a_mode_reg_q) && $stable(cmp_a_input_mux_reg_q))
      else $error("registers moved while frozen");

   // register side
   a_mode_top_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      cmp_a_mode_reg_q[7:6] == 2'h0)
      else $error("mode top bits not zero");

   a_mode_mid_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      cmp_a_mode_reg_q[3:2] == 2'h0)
      else $error("mode middle bits not zero");

   a_mux_top_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      cmp_a_input_mux_reg_q[7:3] == 5'h00)
      else $error("mux upper bits not zero");

   a_mode_reset_val: assert property (@(posedge clk_i)
      (!rst_i && $past(rst_i)) |-> cmp_a_mode_reg_q == 8'h02)
      else $error("mode reset value wrong");

   a_mode_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && wr && hit_mode) |=> ##1 cfg_o.resp_mode == $past(dat_i[1:0], 2))
      else $error("response mode not applied");

   a_mux_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && wr && hit_mux) |=> cmp_a_input_mux_reg_q == {5'h00, $past(dat_i[2:0])})
      else $error("mux select not stored");

   a_cfg_sel_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> cfg_o.pos_sel == $past(cmp_a_input_mux_reg_q[2:0]))
      else $error("positive select not passed on");

   a_cfg_en_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> {cfg_o.rise_en, cfg_o.fall_en} == $past(cmp_a_mode_reg_q[5:4]))
      else $error("edge enables not passed on");

   // edge side
   a_rise_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && $past(ce_i) && $rose(cmp_out_i) && cmp_a_mode_reg_q[5]) |=> rise_irq_o)
      else $error("rising edge irq missing");

   a_rise_block: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !cmp_a_mode_reg_q[5]) |=> !rise_irq_o)
      else $error("rising irq while disabled");

   a_fall_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !cmp_a_mode_reg_q[4]) |=> !fall_irq_o)
      else $error("falling irq while disabled");

   a_fall_fire: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && $past(ce_i) && $fell(cmp_out_i) && cmp_a_mode_reg_q[4]) |=> fall_irq_o)
      else $error("falling edge irq missing");

   a_irq_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
      !(rise_irq_o && fall_irq_o))
      else $error("both edge pulses at once");

endmodule // cmpz_regs
`default_nettype wire

// file: testbench/cmpz_regs_bench.sv
// testbench: register access and edge interrupt checks for comparator zero config bank
`timescale 1ns/1ns
`default_nettype none
module cmpz_regs_bench;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic                clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, cmp_out_i = 0;
   logic [7:0]          adr_i = 8'h00, dat_i = 8'h00, v, dat_o;
   logic [0:0]          sel_i = 1'h1;
   logic                ack_o, rise_irq_o, fall_irq_o;
   cmpz_pkg::cmpz_cfg_t cfg_o;
   logic [7:0]          exp_q[$];
   int                  num_errors = 0, tests_run = 0;
   integer              n_rise = 0, n_fall = 0, r0, f0;
   logic [7:0]          exp_rd;
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, s); end end
   cmpz_regs i_cmpz_regs (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .cmp_out_i(cmp_out_i), .cfg_o(cfg_o), .rise_irq_o(rise_irq_o), .fall_irq_o(fall_irq_o));
   initial forever #10 clk_i = ~clk_i;
   // ----------------------------------------
   // monitor: oldest note against each read answer
   // ----------------------------------------
   always @(posedge clk_i) begin
      n_rise += rise_irq_o;
      n_fall += fall_irq_o;
      if (ack_o === 1'b1 && we_i === 1'b0) begin
         exp_rd = exp_q.pop_front();
         `CHK("read data", exp_rd, dat_o)
      end
   end
   task automatic stop_test();
      if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // bounded wait: a slave that never acks ends the run
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [0:0] s);
      int k;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, s};
      k = 0;
      do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1 && k < 50);
      if (k >= 50) begin
         num_errors++;
         stop_test();
      end else begin
         {cyc_i, stb_i} <= 2'h0;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 8'h00, 1'h1);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(32'h6b700d18));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(cmpz_pkg::MODE_OFFSET, 8'h02);
      rd(cmpz_pkg::MUX_OFFSET, 8'h00);
      for (int m = 0; m < 4; m++) begin
         v = $urandom();
         v[1:0] = m[1:0];
         bus(1'b1, cmpz_pkg::MODE_OFFSET, v, 1'h1);
         rd(cmpz_pkg::MODE_OFFSET, v & 8'h33);
         `CHK("response mode", m[1:0], cfg_o.resp_mode)
      end
      for (int p = 0; p < 8; p++) begin
         v = $urandom();
         v[2:0] = p[2:0];
         bus(1'b1, cmpz_pkg::MUX_OFFSET, v, 1'h1);
         rd(cmpz_pkg::MUX_OFFSET, {5'h00, p[2:0]});
         `CHK("positive select", p[2:0], cfg_o.pos_sel)
      end
      bus(1'b1, cmpz_pkg::MUX_OFFSET, 8'h02, 1'h0);
      rd(cmpz_pkg::MUX_OFFSET, 8'h07);
      bus(1'b1, 8'h55, 8'hff, 1'h1);
      rd(8'h55, 8'h00);
      // every enable pair, one rising and one falling edge each
      for (int e = 0; e < 4; e++) begin
         bus(1'b1, cmpz_pkg::MODE_OFFSET, {2'h0, e[1:0], 4'h0}, 1'h1);
         r0 = n_rise;
         f0 = n_fall;
         cmp_out_i <= 1'b1;
         repeat (4) @(posedge clk_i);
         cmp_out_i <= 1'b0;
         repeat (4) @(posedge clk_i);
         `CHK("rise pulses", e / 2, n_rise - r0)
         `CHK("fall pulses", e % 2, n_fall - f0)
         `CHK("edge enables", e[1:0], {cfg_o.rise_en, cfg_o.fall_en})
      end
      // live comparator level on the status address
      cmp_out_i <= 1'b1;
      rd(cmpz_pkg::STAT_OFFSET, 8'h01);
      cmp_out_i <= 1'b0;
      rd(cmpz_pkg::STAT_OFFSET, 8'h00);
      // frozen clock enable: edges pass unseen, nothing pulses
      ce_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      r0 = n_rise;
      f0 = n_fall;
      cmp_out_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      cmp_out_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      ce_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("frozen pulses", 0, (n_rise - r0) + (n_fall - f0))
      // second reset mid-run
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(cmpz_pkg::MODE_OFFSET, 8'h02);
      rd(cmpz_pkg::MUX_OFFSET, 8'h00);
      stop_test();
   end
endmodule // cmpz_regs_bench
`default_nettype wire
